// ==== bench/lsc_lpc_host.sv ====
`timescale 1ns/1ns
`default_nettype none

module lsc_lpc_host (
    // Bus clock
    input  wire logic       aclk,
    // LPC pins
    output var  logic       lclk,
    output var  logic       lreset_n,
    output var  logic       lpcpd_n,
    // Engine events: match, done, abort, frame start, frame end
    output var  logic [4:0] ev,
    output var  logic       quiet,
    output var  logic       pending
);
    bit run;
    initial begin
        {run, lclk, ev, quiet, pending} = '0;
        {lreset_n, lpcpd_n} = 2'h3;
    end
    // Clock stands still while run is low, so the stop detector sees a real stop
    always begin
        #37;
        while (run) begin
            #200 lclk = ~lclk;
        end
    end
    task automatic pulse(input int i);
        @(posedge aclk);
        ev[i] <= 1'h1;
        @(posedge aclk);
        ev[i] <= 1'h0;
    endtask : pulse
    task automatic levels(input logic q, input logic p);
        @(posedge aclk);
        quiet   <= q;
        pending <= p;
    endtask : levels
    task automatic pins(input logic rn, input logic pn);
        @(posedge aclk);
        lreset_n <= rn;
        lpcpd_n  <= pn;
    endtask : pins
endmodule : lsc_lpc_host
`default_nettype wire

// ==== bench/tb_lpc_sideband_status_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none

module tb_lpc_sideband_status_ctrl;
    localparam logic [3:0] A_EN = lsc_pkg::OFF_ENABLES;
    localparam logic [3:0] A_ST = lsc_pkg::OFF_STATUS;
    localparam logic [3:0] A_IS = lsc_pkg::OFF_IRQ_STS;
    localparam logic [3:0] A_IM = lsc_pkg::OFF_IRQ_MASK;
    logic        aclk;
    logic        aresetn = 1'h0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [3:0]  strb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, clk_req, soft_rst, irq;
    logic [1:0]  bresp, rresp, r;
    logic        lclk, lreset_n, lpcpd_n, quiet, pending;
    logic [4:0]  ev;
    logic [2:0]  pin_o, pin_oe, alt_sel, pin_w, en, lv;
    logic [7:0]  d;
    int          n_fail = 0, checks = 0, seed = 52944;

    // Open-drain wires with pull-ups
    assign pin_w = (pin_o & pin_oe) | ~pin_oe;

    lsc_lpc_host host (.aclk(aclk), .lclk(lclk), .lreset_n(lreset_n), .lpcpd_n(lpcpd_n),
        .ev(ev), .quiet(quiet), .pending(pending));
    lsc_top uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .lclk_pin(lclk), .lreset_n_pin(lreset_n), .lpcpd_n_pin(lpcpd_n),
        .cyc_match(ev[4]), .cyc_done(ev[3]), .cyc_abort(ev[2]), .serirq_start(ev[1]),
        .serirq_end(ev[0]), .serirq_quiet(quiet), .irq_pending(pending), .sb_pin_i(pin_w),
        .sb_pin_o(pin_o), .sb_pin_oe(pin_oe), .sb_alt_sel(alt_sel),
        .clock_restart_request(clk_req), .soft_interface_reset(soft_rst), .irq(irq));

    initial begin
        aclk = 1'h0;
        forever #25 aclk = ~aclk;
    end

    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    function automatic logic [7:0] sb_exp(input logic [2:0] e, input logic [2:0] l, input int k);
        logic [2:0] oe;
        oe = e & ~l;
        return {5'h0, (k == 0) ? oe : (k == 1) ? ~oe : ~e};
    endfunction : sb_exp
    task automatic w8(input int n);
        repeat (n) @(negedge aclk);
    endtask : w8
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic axw(input logic [3:0] a, input logic [7:0] v);
        bit got = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, v};
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        while (!got) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) begin
                got = 1'b1;
                r = bresp;
                bready <= 1'h0;
            end
        end
    endtask : axw
    task automatic rd(input logic [3:0] a, input string nm, input logic [7:0] e);
        bit got = 1'b0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        while (!got) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) begin
                got = 1'b1;
                d = rdata[7:0];
                r = rresp;
                rready <= 1'h0;
            end
        end
        chk(nm, e, d);
    endtask : rd
    task automatic give_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        give_verdict();
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        w8(6);
        rd(A_EN, "enables", 8'h00);
        rd(A_ST, "status", 8'h00);
        chk("alt_sel", 8'h07, {5'h0, alt_sel});
        chk("pin_oe", 8'h00, {5'h0, pin_oe});
        $display("test reset end");
        for (int i = 0; i < 24; i++) begin
            {en, lv} = (i == 0) ? 6'h38 : (i == 1) ? 6'h3F : 6'($random(seed));
            axw(A_EN, {5'h0, en});
            axw(A_ST, {5'h0, lv});
            w8(2);
            chk("pin_oe", sb_exp(en, lv, 0), {5'h0, pin_oe});
            chk("pin_wire", sb_exp(en, lv, 1), {5'h0, pin_w});
            chk("alt_sel", sb_exp(en, lv, 2), {5'h0, alt_sel});
        end
        axw(4'h2, 8'h07);
        chk("bresp", {6'h0, lsc_pkg::RESP_SLVERR}, {6'h0, r});
        strb <= 4'hE;
        axw(A_EN, 8'h00);
        strb <= 4'hF;
        chk("bresp lane", {6'h0, lsc_pkg::RESP_OKAY}, {6'h0, r});
        rd(A_EN, "enables", {5'h0, en});
        chk("rresp", {6'h0, lsc_pkg::RESP_OKAY}, {6'h0, r});
        rd(4'h6, "unaligned", 8'h00);
        chk("rresp bad", {6'h0, lsc_pkg::RESP_SLVERR}, {6'h0, r});
        axw(A_EN, 8'h00);
        axw(A_ST, 8'h00);
        $display("test sideband end");
        host.pulse(4);
        rd(A_ST, "busy set", 8'h80);
        host.pulse(3);
        rd(A_ST, "busy done", 8'h00);
        host.pulse(4);
        host.pulse(2);
        rd(A_ST, "busy abort", 8'h00);
        host.pulse(1);
        rd(A_ST, "frame busy", 8'h20);
        host.pulse(0);
        rd(A_ST, "frame end", 8'h00);
        host.levels(1'h0, 1'h1);
        w8(30);
        chk("clk_req loud", 8'h00, {7'h0, clk_req});
        host.run = 1'b1;
        w8(12);
        host.levels(1'h1, 1'h1);
        w8(40);
        chk("clk_req run", 8'h00, {7'h0, clk_req});
        host.run = 1'b0;
        w8(40);
        chk("clk_req stop", 8'h01, {7'h0, clk_req});
        rd(A_ST, "clk_req bit", 8'h40);
        host.levels(1'h1, 1'h0);
        w8(4);
        chk("clk_req clr", 8'h00, {7'h0, clk_req});
        for (int k = 0; k < 2; k++) begin
            host.levels(1'h1, 1'h1);
            host.pulse(4);
            host.pulse(1);
            w8(30);
            rd(A_ST, "flags set", 8'hE0);
            host.pins(k == 1, k == 0);
            w8(6);
            rd(A_ST, "flags reset", 8'h00);
            host.levels(1'h0, 1'h0);
            host.pins(1'h1, 1'h1);
            w8(6);
        end
        $display("test flags end");
        axw(A_ST, 8'h00);
        axw(A_ST, 8'h10);
        rd(A_ST, "soft unarmed", 8'h00);
        axw(A_ST, 8'h10);
        host.pulse(4);
        rd(A_ST, "soft set", 8'h10);
        chk("soft pin", 8'h01, {7'h0, soft_rst});
        axw(A_ST, 8'h00);
        rd(A_ST, "soft write0", 8'h00);
        axw(A_ST, 8'h10);
        host.pins(1'h0, 1'h1);
        w8(6);
        host.pins(1'h1, 1'h1);
        w8(6);
        rd(A_ST, "soft hard", 8'h00);
        $display("test soft reset end");
        axw(A_IS, 8'h0F);
        axw(A_IM, 8'h00);
        host.pulse(1);
        host.pulse(0);
        rd(A_IS, "irq sts", 8'h04);
        chk("irq masked", 8'h00, {7'h0, irq});
        axw(A_IM, 8'h04);
        w8(2);
        chk("irq on", 8'h01, {7'h0, irq});
        axw(A_IS, 8'h04);
        w8(2);
        chk("irq clr", 8'h00, {7'h0, irq});
        $display("test irq end");
        axw(A_EN, 8'h07);
        axw(A_ST, 8'h05);
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        w8(6);
        rd(A_EN, "enables rst2", 8'h00);
        rd(A_ST, "levels rst2", 8'h00);
        chk("alt_sel rst2", 8'h07, {5'h0, alt_sel});
        $display("test reset2 end");
        give_verdict();
    end
endmodule : tb_lpc_sideband_status_ctrl
`default_nettype wire

// ==== hdl/lsc_pkg.sv ====
`default_nettype none

package lsc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W        = 4;
    localparam logic [3:0]  OFF_ENABLES   = 4'h0;
    localparam logic [3:0]  OFF_STATUS    = 4'h4;
    localparam logic [3:0]  OFF_IRQ_STS   = 4'h8;
    localparam logic [3:0]  OFF_IRQ_MASK  = 4'hC;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned NUM_SB        = 3;
    localparam int unsigned SB_PWR_EVT    = 2;
    localparam int unsigned SB_MGMT_IRQ   = 1;
    localparam int unsigned SB_CTRL_IRQ   = 0;
    localparam int unsigned ST_BUSY       = 7;
    localparam int unsigned ST_CLOCK_RESTART_REQUEST     = 6;
    localparam int unsigned ST_SERIAL_IRQ_BUSY     = 5;
    localparam int unsigned ST_SOFT_RST   = 4;
    localparam int unsigned NUM_EV        = 4;
    localparam int unsigned EV_BUSY       = 0;
    localparam int unsigned EV_CLOCK_RESTART_REQUEST     = 1;
    localparam int unsigned EV_FRAME      = 2;
    localparam int unsigned EV_HW_RST     = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0]  SB_EN_RST     = 3'h0;
    localparam logic [2:0]  SB_LVL_RST    = 3'h0;
    localparam logic [3:0]  IRQ_RST       = 4'h0;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned LCLK_STOP_NS  = 1000;
    localparam int unsigned LCLK_STOP_CYC = (LCLK_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STOP_CNT_W    = 5;

endpackage : lsc_pkg

`default_nettype wire

// ==== hdl/lsc_sideband.sv ====
`timescale 1ns/1ns
`default_nettype none

module lsc_sideband (
    // Clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // Control bits
    input  wire logic [lsc_pkg::NUM_SB-1:0] out_en,
    input  wire logic [lsc_pkg::NUM_SB-1:0] out_level,
    // Open-drain pins
    output var  logic [lsc_pkg::NUM_SB-1:0] pin_o,
    output var  logic [lsc_pkg::NUM_SB-1:0] pin_oe,
    output var  logic [lsc_pkg::NUM_SB-1:0] alt_sel
);

    // ------------------------------------------------------------
    // One open-drain channel per sideband pin
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < lsc_pkg::NUM_SB; i++) begin : g_ch
            wire logic drive_low = out_en[i] & ~out_level[i];
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_o[i]   <= 1'b0;
                    pin_oe[i]  <= 1'b0;
                    alt_sel[i] <= 1'b1;
                end else begin
                    pin_o[i]   <= 1'b0;
                    pin_oe[i]  <= drive_low;
                    alt_sel[i] <= ~out_en[i];
                end
            end
        end
    endgenerate

endmodule : lsc_sideband

`default_nettype wire

// ==== hdl/lsc_sync3.sv ====
`timescale 1ns/1ns
`default_nettype none

module lsc_sync3 #(
    parameter int unsigned W = 3
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Raw and filtered levels
    input  wire logic [W-1:0] raw,
    output var  logic [W-1:0] clean
);

    // ------------------------------------------------------------
    // Three stages; a change counts once stages two and three agree
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_r, s2_r, s3_r;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s1_r     <= 1'b0;
                    s2_r     <= 1'b0;
                    s3_r     <= 1'b0;
                    clean[i] <= 1'b0;
                end else begin
                    s1_r <= raw[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r) clean[i] <= s3_r;
                end
            end
        end
    endgenerate

endmodule : lsc_sync3

`default_nettype wire

// ==== hdl/lsc_top.sv ====
// Contract
// - Power-event pin: enable 0 gives alternate function; enable 1 drives low or floats.
// - Management-interrupt pin: enable 0 other function; enable 1 low or Hi-Z by level.
// - Control-interrupt pin: enable 0 other function; enable 1 low or floats by level.
// - Transfer-busy sets when cycle type and address match a processed cycle.
// - Transfer-busy reads 0 when idle, foreign cycle, or type/address unknown.
// - Transfer-busy clears on normal end or host abort of processed cycle.
// - Busy, clock-request, serial-busy flags clear on interface reset or shutdown.
// - Quiet mode, interrupt pending, link clock stopped: set clock-restart request.
// - Clock-restart request clears once no interrupts remain to send.
// - Serial-IRQ-busy sets at start of a serial IRQ frame.
// - Serial-IRQ-busy clears at end of the serial IRQ frame.
// - Soft reset sets only on writing 1 after reading 0; clears on 0 or hard reset.
`timescale 1ns/1ns
`default_nettype none

module lsc_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // LPC pins (asynchronous)
    input  wire logic        lclk_pin,
    input  wire logic        lreset_n_pin,
    input  wire logic        lpcpd_n_pin,
    // LPC engine events (aclk domain)
    input  wire logic        cyc_match,
    input  wire logic        cyc_done,
    input  wire logic        cyc_abort,
    input  wire logic        serirq_start,
    input  wire logic        serirq_end,
    input  wire logic        serirq_quiet,
    input  wire logic        irq_pending,
    // Sideband open-drain pins: [2] power event, [1] mgmt irq, [0] ctrl irq
    input  wire logic [2:0]  sb_pin_i,
    output var  logic [2:0]  sb_pin_o,
    output var  logic [2:0]  sb_pin_oe,
    output var  logic [2:0]  sb_alt_sel,
    // Status outputs
    output var  logic        clock_restart_request,
    output var  logic        soft_interface_reset,
    output var  logic        irq
);

    // ------------------------------------------------------------
    // Pin synchronisers and link clock watch
    // ------------------------------------------------------------
    logic [2:0]                       pins_s;
    logic                             lclk_prev_r;
    logic                             lreset_prev_r;
    logic [lsc_pkg::STOP_CNT_W-1:0]   stop_cnt_r;
    logic [lsc_pkg::STOP_CNT_W-1:0]   stop_cnt_nxt;

    lsc_sync3 #(.W(3)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw     ({lclk_pin, lreset_n_pin, lpcpd_n_pin}),
        .clean   (pins_s)
    );

    localparam logic [lsc_pkg::STOP_CNT_W-1:0] STOP_MAX =
        lsc_pkg::STOP_CNT_W'(lsc_pkg::LCLK_STOP_CYC);

    wire logic lclk_s       = pins_s[2];
    wire logic lreset_n_s   = pins_s[1];
    wire logic lpcpd_n_s    = pins_s[0];
    wire logic lclk_edge    = lclk_s ^ lclk_prev_r;
    wire logic lclk_stopped = (stop_cnt_r == STOP_MAX);
    wire logic hw_rst_fall  = lreset_prev_r & ~lreset_n_s;

    assign stop_cnt_nxt = lclk_edge    ? '0 :
                          lclk_stopped ? stop_cnt_r :
                                         stop_cnt_r + lsc_pkg::STOP_CNT_W'(1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lclk_prev_r   <= 1'b0;
            lreset_prev_r <= 1'b0;
            stop_cnt_r    <= '0;
        end else begin
            lclk_prev_r   <= lclk_s;
            lreset_prev_r <= lreset_n_s;
            stop_cnt_r    <= stop_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite handshakes
    // ------------------------------------------------------------
    logic       aw_held_r, w_held_r;
    logic [3:0] awaddr_r;
    logic [7:0] wbyte_r;
    logic       wlane_r;
    logic [3:0] araddr_r;

    wire logic aw_take     = s_axi_awvalid & s_axi_awready;
    wire logic w_take      = s_axi_wvalid & s_axi_wready;
    wire logic ar_take     = s_axi_arvalid & s_axi_arready;
    wire logic wr_fire     = aw_held_r & w_held_r & ~s_axi_bvalid;
    wire logic aw_held_nxt = (aw_held_r & ~wr_fire) | aw_take;
    wire logic w_held_nxt  = (w_held_r & ~wr_fire) | w_take;
    wire logic bvalid_nxt  = wr_fire | (s_axi_bvalid & ~s_axi_bready);
    wire logic rvalid_nxt  = ar_take | (s_axi_rvalid & ~s_axi_rready);

    // Narrow registers live in byte lane 0; other lanes are ignored
    wire logic wr_do     = wr_fire & wlane_r;
    wire logic wr_en_reg = wr_do & (awaddr_r == lsc_pkg::OFF_ENABLES);
    wire logic wr_st_reg = wr_do & (awaddr_r == lsc_pkg::OFF_STATUS);
    wire logic wr_is_reg = wr_do & (awaddr_r == lsc_pkg::OFF_IRQ_STS);
    wire logic wr_mk_reg = wr_do & (awaddr_r == lsc_pkg::OFF_IRQ_MASK);
    wire logic wr_mapped = (awaddr_r[1:0] == 2'h0);
    wire logic rd_mapped = (s_axi_araddr[1:0] == 2'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            awaddr_r      <= 4'h0;
            wbyte_r       <= 8'h00;
            wlane_r       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= lsc_pkg::RESP_OKAY;
        end else begin
            aw_held_r     <= aw_held_nxt;
            w_held_r      <= w_held_nxt;
            s_axi_awready <= ~aw_held_nxt;
            s_axi_wready  <= ~w_held_nxt;
            s_axi_bvalid  <= bvalid_nxt;
            if (aw_take) awaddr_r <= s_axi_awaddr;
            if (w_take) begin
                wbyte_r <= s_axi_wdata[7:0];
                wlane_r <= s_axi_wstrb[0];
            end
            if (wr_fire) s_axi_bresp <= wr_mapped ? lsc_pkg::RESP_OKAY : lsc_pkg::RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [2:0] sb_en_r, sb_lvl_r;
    logic       soft_rst_r, soft_arm_r;
    logic [3:0] irq_sts_r, irq_mask_r;
    logic       busy_r, clock_restart_request_r, serial_irq_busy_r;

    wire logic rd_status = ar_take & (s_axi_araddr == lsc_pkg::OFF_STATUS);
    // Interrupt output follows a mask write in the same cycle as the mask itself
    wire logic [3:0] irq_mask_nxt = wr_mk_reg ? wbyte_r[3:0] : irq_mask_r;
    wire logic soft_rst_nxt = ~lreset_n_s ? 1'b0 :
                              wr_st_reg   ? wbyte_r[lsc_pkg::ST_SOFT_RST] &
                                            (soft_rst_r | soft_arm_r) :
                                            soft_rst_r;
    wire logic soft_arm_nxt = ~lreset_n_s ? 1'b0 :
                              wr_st_reg   ? 1'b0 :
                              rd_status   ? ~soft_rst_r | soft_arm_r :
                                            soft_arm_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sb_en_r    <= lsc_pkg::SB_EN_RST;
            sb_lvl_r   <= lsc_pkg::SB_LVL_RST;
            soft_rst_r <= 1'b0;
            soft_arm_r <= 1'b0;
            irq_mask_r <= lsc_pkg::IRQ_RST;
        end else begin
            if (wr_en_reg) sb_en_r <= wbyte_r[2:0];
            if (wr_st_reg) sb_lvl_r <= wbyte_r[2:0];
            if (wr_mk_reg) irq_mask_r <= wbyte_r[3:0];
            soft_rst_r <= soft_rst_nxt;
            soft_arm_r <= soft_arm_nxt;
        end
    end

    // ------------------------------------------------------------
    // Interface activity flags
    // ------------------------------------------------------------
    // Software shutdown is handled elsewhere; only the pin shutdown is seen here
    wire logic lpc_rst = ~lreset_n_s | soft_rst_r | ~lpcpd_n_s;

    wire logic busy_nxt   = lpc_rst                 ? 1'b0 :
                            cyc_match               ? 1'b1 :
                            (cyc_done | cyc_abort)  ? 1'b0 :
                                                      busy_r;
    wire logic clock_restart_request_set = serirq_quiet & irq_pending & lclk_stopped;
    wire logic clock_restart_request_nxt = lpc_rst      ? 1'b0 :
                            clock_restart_request_set   ? 1'b1 :
                            ~irq_pending ? 1'b0 :
                                           clock_restart_request_r;
    wire logic serial_irq_busy_nxt = lpc_rst      ? 1'b0 :
                            serirq_start ? 1'b1 :
                            serirq_end   ? 1'b0 :
                                           serial_irq_busy_r;

    // Hardware events win over a simultaneous write-one-to-clear
    wire logic [3:0] ev = {hw_rst_fall, serirq_start & ~lpc_rst,
                           clock_restart_request_nxt & ~clock_restart_request_r, busy_nxt & ~busy_r};
    wire logic [3:0] w1c = wr_is_reg ? wbyte_r[3:0] : 4'h0;
    wire logic [3:0] irq_sts_nxt = (irq_sts_r & ~w1c) | ev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_r    <= 1'b0;
            clock_restart_request_r  <= 1'b0;
            serial_irq_busy_r  <= 1'b0;
            irq_sts_r <= lsc_pkg::IRQ_RST;
            irq       <= 1'b0;
        end else begin
            busy_r    <= busy_nxt;
            clock_restart_request_r  <= clock_restart_request_nxt;
            serial_irq_busy_r  <= serial_irq_busy_nxt;
            irq_sts_r <= irq_sts_nxt;
            irq       <= |(irq_sts_nxt & irq_mask_nxt);
        end
    end

    assign clock_restart_request = clock_restart_request_r;
    assign soft_interface_reset  = soft_rst_r;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire logic [7:0] st_word = {busy_r, clock_restart_request_r, serial_irq_busy_r, soft_rst_r, 1'b0, sb_lvl_r};
    wire logic [7:0] rd_byte =
        (s_axi_araddr == lsc_pkg::OFF_ENABLES)  ? {5'h00, sb_en_r} :
        (s_axi_araddr == lsc_pkg::OFF_STATUS)   ? st_word :
        (s_axi_araddr == lsc_pkg::OFF_IRQ_STS)  ? {4'h0, irq_sts_r} :
        (s_axi_araddr == lsc_pkg::OFF_IRQ_MASK) ? {4'h0, irq_mask_r} : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= lsc_pkg::RESP_OKAY;
            araddr_r      <= 4'h0;
        end else begin
            s_axi_arready <= ~rvalid_nxt;
            s_axi_rvalid  <= rvalid_nxt;
            if (ar_take) begin
                araddr_r    <= s_axi_araddr;
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= rd_mapped ? lsc_pkg::RESP_OKAY : lsc_pkg::RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // Sideband pin drivers
    // ------------------------------------------------------------
    lsc_sideband u_sb (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .out_en    (sb_en_r),
        .out_level (sb_lvl_r),
        .pin_o     (sb_pin_o),
        .pin_oe    (sb_pin_oe),
        .alt_sel   (sb_alt_sel)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    pwr_evt_pin_a: assert property (sb_en_r[2] |=> (sb_pin_oe[2] == ~$past(sb_lvl_r[2])) && !sb_alt_sel[2])
        else $error("power event pin drive wrong");
    mgmt_irq_pin_a: assert property (sb_en_r[1] && !sb_lvl_r[1] |=> sb_pin_oe[1] && !sb_pin_o[1])
        else $error("mgmt irq pin not driven low");
    ctrl_irq_pin_a: assert property (!sb_en_r[0] |=> sb_alt_sel[0] && !sb_pin_oe[0])
        else $error("ctrl irq pin not released");
    busy_set_a: assert property (cyc_match && !lpc_rst |=> busy_r)
        else $error("busy not set on match");
    busy_cause_a: assert property ($rose(busy_r) |-> $past(cyc_match))
        else $error("busy set without match");
    busy_clear_a: assert property ((cyc_done || cyc_abort) && !cyc_match |=> !busy_r)
        else $error("busy not cleared on end");
    flags_reset_a: assert property (lpc_rst |=> !busy_r && !clock_restart_request_r && !serial_irq_busy_r)
        else $error("flags survive interface reset");
    clock_restart_request_set_a: assert property (clock_restart_request_set && !lpc_rst |=> clock_restart_request)
        else $error("clock restart not requested");
    clock_restart_request_clear_a: assert property (!irq_pending && !clock_restart_request_set |=> !clock_restart_request_r)
        else $error("clock request not cleared");
    frame_busy_a: assert property (serirq_start && !lpc_rst |=> serial_irq_busy_r)
        else $error("serial busy not set");
    frame_end_a: assert property (serirq_end && !serirq_start |=> !serial_irq_busy_r)
        else $error("serial busy not cleared");
    soft_rst_a: assert property ($rose(soft_rst_r) |-> $past(soft_arm_r) && $past(wr_st_reg))
        else $error("soft reset set without prior read");
    irq_out_a: assert property (|(irq_sts_r & irq_mask_r) |-> irq)
        else $error("interrupt output low with pending bit");

    wr_seen_c: cover property (s_axi_bvalid && s_axi_bready);
    busy_seen_c: cover property ($rose(busy_r) ##[1:20] !busy_r);
    clock_restart_request_seen_c: cover property ($rose(clock_restart_request_r));
    frame_seen_c: cover property ($rose(serial_irq_busy_r) ##[1:100] $fell(serial_irq_busy_r));

endmodule : lsc_top

`default_nettype wire
